// [common/acd_pkg.sv]
/*
 Package for the accessory detect and auto-configuration block: ID codes,
 switch path encodings, timing counts and reset values.
 Assumes a single 40 MHz system clock.
*/
package acd_pkg;
	localparam int unsigned CLK_HZ = 40000000;
	localparam int unsigned BUS_RESET_MS = 30;
	localparam int unsigned BUS_RESET_CYC = CLK_HZ / 1000 * BUS_RESET_MS;

	localparam logic [4:0] ID_USB_OTG = 5'h00;
	localparam logic [4:0] ID_SEND_END = 5'h01;
	localparam logic [4:0] ID_KEY_LAST = 5'h0D;
	localparam logic [4:0] ID_RSV_FIRST = 5'h0E;
	localparam logic [4:0] ID_RSV_LAST = 5'h12;
	localparam logic [4:0] ID_AUDIO_T2 = 5'h13;
	localparam logic [4:0] ID_PHONE_PWR = 5'h14;
	localparam logic [4:0] ID_TTY_CONV = 5'h15;
	localparam logic [4:0] ID_UART = 5'h16;
	localparam logic [4:0] ID_CHG_T1 = 5'h17;
	localparam logic [4:0] ID_FAC_USB_OFF = 5'h18;
	localparam logic [4:0] ID_FAC_USB_ON = 5'h19;
	localparam logic [4:0] ID_AV_CABLE = 5'h1A;
	localparam logic [4:0] ID_CHG_T2 = 5'h1B;
	localparam logic [4:0] ID_FAC_UART_OFF = 5'h1C;
	localparam logic [4:0] ID_FAC_UART_ON = 5'h1D;
	localparam logic [4:0] ID_AUDIO_T1 = 5'h1E;
	localparam logic [4:0] ID_OPEN = 5'h1F;

	// Data-line path selections of the four-position mux.
	localparam logic [2:0] PATH_OPEN = 3'h0;
	localparam logic [2:0] PATH_USB = 3'h1;
	localparam logic [2:0] PATH_AUDIO = 3'h2;
	localparam logic [2:0] PATH_UART = 3'h3;
	localparam logic [2:0] PATH_VIDEO = 3'h4;
	localparam logic [2:0] PATH_MIC = 3'h5;

	// Accessory type codes reported to the host.
	localparam logic [3:0] TYPE_NONE = 4'h0;
	localparam logic [3:0] TYPE_KEY = 4'h1;
	localparam logic [3:0] TYPE_AUDIO = 4'h2;
	localparam logic [3:0] TYPE_CHARGER = 4'h3;
	localparam logic [3:0] TYPE_FACTORY = 4'h4;
	localparam logic [3:0] TYPE_UART = 4'h5;
	localparam logic [3:0] TYPE_USB = 4'h6;
	localparam logic [3:0] TYPE_AV = 4'h7;
	localparam logic [3:0] TYPE_OTHER = 4'h8;
	localparam logic [3:0] TYPE_UNSUP = 4'h9;
	localparam logic [3:0] TYPE_DED_CHG = 4'hA;

	localparam logic [4:0] ADC_RESET = 5'h1F;
endpackage : acd_pkg

// [hw/acd_bus_reset_timer.sv]
/*
 Counts how long both two-wire-bus lines stay low and pulses once when the
 hold reaches the reset time.
 Assumes bus line levels are synchronous to clk_sys.
*/
`timescale 1ns/1ps
module acd_bus_reset_timer #(
	parameter int unsigned HOLD_CYC = acd_pkg::BUS_RESET_CYC
) (
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic sclIn,
	input  wire logic sdaIn,
	output logic      busResetPulse
);
	typedef struct packed {
		logic [31:0] cnt;
		logic        fired;
		logic        pulse;
	} acd_tmr_type;

	acd_tmr_type st_r;
	acd_tmr_type st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.pulse = 1'b0;
		if (sclIn || sdaIn) begin
			st_nxt.cnt = 32'h0;
			st_nxt.fired = 1'b0;
		end else if (!st_r.fired) begin
			if (st_r.cnt >= HOLD_CYC - 1) begin
				st_nxt.fired = 1'b1;
				st_nxt.pulse = 1'b1;
			end else begin
				st_nxt.cnt = st_r.cnt + 32'h1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign busResetPulse = st_r.pulse;

	AST_BUS_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(st_r.pulse) |-> $past(!sclIn && !sdaIn))
		else $error("Bus reset pulsed without both lines low.");
endmodule : acd_bus_reset_timer

// [hw/acd_autoconfig.sv]
/*
 Accessory detect and auto-configuration core. Decodes the 5-bit ID code,
 drives the mux path, charger switch, boot, jig and charge-detect outputs,
 and handles power-up, supply-level and two-wire-bus resets.
 Assumes all inputs are synchronous to clk_sys and idCode is settled.
*/
// Operation
// - Code 11111 means open ID: USB cable, dedicated charger or detach.
// - Codes 00001..01101 report send-end and remote key presses.
// - Code 11110 and send-end-only audio report as audio type.
// - Charger codes reported to host only while bus supply valid.
// - Factory USB: host USB path, jig low, charger closed, boot per code.
// - Factory UART: UART path, jig low, charger open, boot per code.
// - Four-position mux with USB, audio, video and UART paths.
// - UART and A/V cable close charger only with valid supply.
// - Keep monitoring ID code for change in listed modes.
// - A/V cable: charge-detect Hi-Z, low when supply also valid.
// - Any charger: close switch, charge-detect low; dedicated leaves lines open.
// - Standard USB: host USB path and closed charger switch.
// - Power-up: defaults, all paths open, then standby.
// - Supply-level falling edge in active state resets to defaults, open paths, standby.
// - After supply high and mask clear, report standby activity.
// - Both bus lines low 30 ms forces full reset.
// - Standby monitors ID and moves to mode decoded on attach.
// - Write ID to ADC register, interrupt; wait starts after host read.
`timescale 1ns/1ps
module acd_autoconfig #(
	parameter int unsigned BUS_HOLD_CYC = acd_pkg::BUS_RESET_CYC,
	parameter int unsigned WAIT_CYC     = 16
) (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic [4:0] idCode,
	input  wire logic       idValid,
	input  wire logic       busSupplyValid,
	input  wire logic       usbChargerSeen,
	input  wire logic       io_supply_level,
	input  wire logic       sclIn,
	input  wire logic       sdaIn,
	input  wire logic       intMask,
	input  wire logic       intReadAck,
	output logic [4:0]      adcCode,
	output logic [3:0]      accessoryType,
	output logic            keyPress,
	output logic            accessoryEvent,
	output logic [2:0]      four_position_mux,
	output logic            chargerSwitchClosed,
	output logic            jigOutLow,
	output logic            jigOutEn,
	output logic            bootLevel,
	output logic            charge_detect_out,
	output logic            chargeDetectEn,
	output logic            switchWaitDone,
	output logic            standbyState
);
	typedef enum logic [2:0] {
		ST_INIT    = 3'b001,
		ST_STANDBY = 3'b010,
		ST_ACTIVE  = 3'b100
	} acd_state_type;

	typedef struct packed {
		acd_state_type state;
		logic [4:0]    lastId;
		logic [4:0]    adc;
		logic [3:0]    accType;
		logic          key;
		logic          pending;
		logic          evt;
		logic          ioPrev;
		logic          waiting;
		logic [15:0]   waitCnt;
		logic          waitDone;
		logic [2:0]    mux;
		logic          chgSw;
		logic          jigEn;
		logic          boot;
		logic          cdEn;
		logic          timing;
		logic          stby;
	} acd_core_type;

	acd_core_type st_r;
	acd_core_type st_nxt;
	logic         busReset;

	// ----------------------------------------------------------------
	// Two-wire-bus reset detection
	// ----------------------------------------------------------------
	acd_bus_reset_timer #(
		.HOLD_CYC(BUS_HOLD_CYC)
	) u_bus_timer (
		.clk_sys      (clk_sys),
		.rst          (rst),
		.sclIn        (sclIn),
		.sdaIn        (sdaIn),
		.busResetPulse(busReset)
	);

	function automatic logic isCharger(input logic [4:0] c);
		return (c == acd_pkg::ID_CHG_T1) || (c == acd_pkg::ID_CHG_T2);
	endfunction : isCharger

	function automatic logic isFactory(input logic [4:0] c);
		return (c == acd_pkg::ID_FAC_USB_OFF) || (c == acd_pkg::ID_FAC_USB_ON) ||
			(c == acd_pkg::ID_FAC_UART_OFF) || (c == acd_pkg::ID_FAC_UART_ON);
	endfunction : isFactory

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		logic ioFall;
		logic newId;
		logic [4:0] c;
		ioFall = 1'b0;
		newId = 1'b0;
		c = idCode;
		st_nxt = st_r;
		st_nxt.ioPrev = io_supply_level;
		st_nxt.evt = 1'b0;
		ioFall = st_r.ioPrev && !io_supply_level;
		if (busReset || (ioFall && st_r.state == ST_ACTIVE)) begin
			st_nxt = '0;
			st_nxt.state = ST_INIT;
			st_nxt.adc = acd_pkg::ADC_RESET;
			st_nxt.lastId = acd_pkg::ID_OPEN;
			st_nxt.ioPrev = io_supply_level;
		end else begin
			unique case (st_r.state)
				ST_INIT: begin
					st_nxt.state = ST_STANDBY;
				end
				ST_STANDBY, ST_ACTIVE: begin
					// The ID keeps being watched in the standby and active states so changes are caught.
					newId = idValid && (c != st_r.lastId);
					if (newId) begin
						st_nxt.lastId = c;
						st_nxt.adc = c;
						st_nxt.pending = 1'b1;
						st_nxt.waiting = 1'b0;
						st_nxt.waitDone = 1'b0;
						st_nxt.timing = 1'b0;
						st_nxt.key = 1'b0;
						st_nxt.mux = acd_pkg::PATH_OPEN;
						st_nxt.chgSw = 1'b0;
						st_nxt.jigEn = 1'b0;
						st_nxt.boot = 1'b0;
						st_nxt.cdEn = 1'b0;
						st_nxt.accType = acd_pkg::TYPE_OTHER;
						st_nxt.state = ST_ACTIVE;
						if (c == acd_pkg::ID_OPEN) begin
							// Open ID covers plain USB, dedicated charger or detach.
							if (usbChargerSeen && busSupplyValid) begin
								st_nxt.accType = acd_pkg::TYPE_DED_CHG;
								st_nxt.chgSw = 1'b1;
								st_nxt.cdEn = 1'b1;
							end else if (busSupplyValid) begin
								st_nxt.accType = acd_pkg::TYPE_USB;
								st_nxt.mux = acd_pkg::PATH_USB;
								st_nxt.chgSw = 1'b1;
							end else begin
								st_nxt.accType = acd_pkg::TYPE_NONE;
								st_nxt.pending = 1'b0;
								st_nxt.state = ST_STANDBY;
							end
						end else if (c == acd_pkg::ID_USB_OTG) begin
							st_nxt.accType = acd_pkg::TYPE_USB;
							st_nxt.mux = acd_pkg::PATH_USB;
						end else if (c >= acd_pkg::ID_SEND_END && c <= acd_pkg::ID_KEY_LAST) begin
							st_nxt.accType = acd_pkg::TYPE_KEY;
							st_nxt.key = 1'b1;
							st_nxt.mux = acd_pkg::PATH_AUDIO;
						end else if (c >= acd_pkg::ID_RSV_FIRST && c <= acd_pkg::ID_RSV_LAST) begin
							st_nxt.accType = acd_pkg::TYPE_UNSUP;
						end else if (isCharger(c)) begin
							st_nxt.pending = busSupplyValid;
							st_nxt.accType = busSupplyValid ? acd_pkg::TYPE_CHARGER
								: acd_pkg::TYPE_NONE;
							st_nxt.chgSw = busSupplyValid;
							st_nxt.cdEn = busSupplyValid;
						end else if (isFactory(c)) begin
							st_nxt.accType = acd_pkg::TYPE_FACTORY;
							st_nxt.jigEn = 1'b1;
							st_nxt.boot = (c == acd_pkg::ID_FAC_USB_ON) ||
								(c == acd_pkg::ID_FAC_UART_ON);
							if (c == acd_pkg::ID_FAC_USB_OFF || c == acd_pkg::ID_FAC_USB_ON) begin
								st_nxt.mux = acd_pkg::PATH_USB;
								st_nxt.chgSw = 1'b1;
							end else begin
								st_nxt.mux = acd_pkg::PATH_UART;
							end
						end else begin
							unique case (c)
								acd_pkg::ID_AUDIO_T1: begin
									st_nxt.accType = acd_pkg::TYPE_AUDIO;
									st_nxt.mux = acd_pkg::PATH_AUDIO;
								end
								acd_pkg::ID_AUDIO_T2: begin
									st_nxt.accType = acd_pkg::TYPE_AUDIO;
									st_nxt.mux = acd_pkg::PATH_UART;
									st_nxt.chgSw = 1'b1;
								end
								acd_pkg::ID_PHONE_PWR: begin
									st_nxt.mux = acd_pkg::PATH_AUDIO;
									st_nxt.chgSw = 1'b1;
								end
								acd_pkg::ID_TTY_CONV: begin
									st_nxt.mux = acd_pkg::PATH_MIC;
								end
								acd_pkg::ID_UART: begin
									st_nxt.accType = acd_pkg::TYPE_UART;
									st_nxt.mux = acd_pkg::PATH_UART;
									st_nxt.chgSw = busSupplyValid;
								end
								acd_pkg::ID_AV_CABLE: begin
									st_nxt.accType = acd_pkg::TYPE_AV;
									st_nxt.mux = acd_pkg::PATH_VIDEO;
									st_nxt.chgSw = busSupplyValid;
									st_nxt.cdEn = busSupplyValid;
								end
								default: begin
									st_nxt.accType = acd_pkg::TYPE_UNSUP;
								end
							endcase
						end
					end else if (st_r.state == ST_ACTIVE) begin
						// UART and A/V cable outputs follow the supply while attached.
						if (st_r.lastId == acd_pkg::ID_UART || st_r.lastId == acd_pkg::ID_AV_CABLE) begin
							st_nxt.chgSw = busSupplyValid;
						end
						if (st_r.lastId == acd_pkg::ID_AV_CABLE) begin
							st_nxt.cdEn = busSupplyValid;
						end
					end
					// The wait runs only after the host has read the report, and a new
					// code abandons the wait of the old one.
					if (st_r.waiting && intReadAck && !newId) begin
						st_nxt.waitCnt = 16'h0;
						st_nxt.waiting = 1'b0;
						st_nxt.timing = 1'b1;
					end else if (st_r.timing && !newId) begin
						if (st_r.waitCnt >= WAIT_CYC[15:0] - 16'h1) begin
							st_nxt.waitDone = 1'b1;
							st_nxt.timing = 1'b0;
						end else begin
							st_nxt.waitCnt = st_r.waitCnt + 16'h1;
						end
					end
					// Report is held until supply is up and the mask is clear.
					// Placed after the read handling so that a new report wins.
					if (st_nxt.pending && io_supply_level && !intMask) begin
						st_nxt.evt = 1'b1;
						st_nxt.pending = 1'b0;
						st_nxt.waiting = 1'b1;
					end
				end
				default: begin
					st_nxt.state = ST_INIT;
				end
			endcase
		end
		st_nxt.stby = (st_nxt.state != ST_ACTIVE);
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_r <= '0;
			st_r.stby <= 1'b1;
			st_r.state <= ST_INIT;
			st_r.adc <= acd_pkg::ADC_RESET;
			st_r.lastId <= acd_pkg::ID_OPEN;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign adcCode = st_r.adc;
	assign accessoryType = st_r.accType;
	assign keyPress = st_r.key;
	assign accessoryEvent = st_r.evt;
	assign four_position_mux = st_r.mux;
	assign chargerSwitchClosed = st_r.chgSw;
	assign jigOutLow = 1'b0;
	assign jigOutEn = st_r.jigEn;
	assign bootLevel = st_r.boot;
	assign charge_detect_out = 1'b0;
	assign chargeDetectEn = st_r.cdEn;
	assign switchWaitDone = st_r.waitDone;
	assign standbyState = st_r.stby;

	sequence s_facUsb;
		idValid && (idCode == acd_pkg::ID_FAC_USB_ON) && (idCode != st_r.lastId) &&
			(st_r.state != ST_INIT) && !(st_r.ioPrev && !io_supply_level);
	endsequence

	AST_FAC_USB: assert property (@(posedge clk_sys) disable iff (rst || busReset)
		s_facUsb |=> (four_position_mux == acd_pkg::PATH_USB) && jigOutEn && bootLevel &&
			chargerSwitchClosed)
		else $error("Factory USB boot-on not configured.");
	AST_FAC_UART: assert property (@(posedge clk_sys) disable iff (rst)
		jigOutEn && (four_position_mux == acd_pkg::PATH_UART) |-> !chargerSwitchClosed)
		else $error("Factory UART closed the charger switch.");
	AST_NONFAC: assert property (@(posedge clk_sys) disable iff (rst)
		!jigOutEn |-> !bootLevel)
		else $error("Boot high outside factory mode.");
	AST_CD_SW: assert property (@(posedge clk_sys) disable iff (rst)
		chargeDetectEn |-> chargerSwitchClosed)
		else $error("Charge detect asserted with charger switch open.");
	AST_BUS_RST: assert property (@(posedge clk_sys) disable iff (rst)
		busReset |=> (four_position_mux == acd_pkg::PATH_OPEN) && !chargerSwitchClosed
			##1 standbyState)
		else $error("Bus reset did not open paths.");
	AST_IO_RST: assert property (@(posedge clk_sys) disable iff (rst)
		(st_r.state == ST_ACTIVE) && st_r.ioPrev && !io_supply_level |=>
			(adcCode == acd_pkg::ADC_RESET) && !jigOutEn)
		else $error("Supply-level fall did not reset.");
	AST_EVT_GATE: assert property (@(posedge clk_sys) disable iff (rst)
		accessoryEvent |-> $past(io_supply_level) && !$past(intMask))
		else $error("Event raised while masked or supply low.");
	AST_RSV: assert property (@(posedge clk_sys) disable iff (rst)
		(accessoryType == acd_pkg::TYPE_UNSUP) |-> (four_position_mux == acd_pkg::PATH_OPEN))
		else $error("Reserved accessory closed a path.");
	AST_KEY: assert property (@(posedge clk_sys) disable iff (rst)
		keyPress |-> (adcCode >= acd_pkg::ID_SEND_END) && (adcCode <= acd_pkg::ID_KEY_LAST))
		else $error("Key press outside key code range.");
endmodule : acd_autoconfig

// [sim/acd_partner_model.sv]
/*
 Far-side model: the accessory presenting settled ID codes, and the host
 holding the bus lines and reading interrupts.
 Assumes the bench changes its requests just after a rising clk_sys edge.
*/
`timescale 1ns/1ps
module acd_partner_model (
	input  wire logic       clk_sys,
	input  wire logic [4:0] attachCode,
	input  wire logic       holdBusLow,
	input  wire logic       accessoryEvent,
	output logic [4:0]      idCode,
	output logic            idValid,
	output logic            sclIn,
	output logic            sdaIn,
	output logic            intReadAck
);
	// ----------------------------------------
	// Accessory and host behaviour
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		idCode <= attachCode;
		idValid <= 1'b1;
		// The host reads the interrupt one cycle after it sees the event.
		intReadAck <= accessoryEvent;
	end

	// Both lines have pull-ups, so a released line reads high.
	assign sclIn = holdBusLow ? 1'b0 : 1'b1;
	assign sdaIn = holdBusLow ? 1'b0 : 1'b1;
endmodule : acd_partner_model

// [sim/accessory_detect_autoconfig_bench.sv]
/*
 Self-checking bench for the accessory detect and auto-configuration core.
 Assumes the partner model registers each code one cycle before the core.
*/
`timescale 1ns/1ps
module accessory_detect_autoconfig_bench;
	logic       clk_sys, rst, busSupplyValid, usbChargerSeen, io_supply_level;
	logic       intMask, holdBusLow, idValid, sclIn, sdaIn, intReadAck;
	logic [4:0] attachCode, idCode, adcCode;
	logic [3:0] accessoryType;
	logic [2:0] fourMux;
	logic       keyPress, accessoryEvent, chgSw, jigLow, jigEn, bootLevel;
	logic       cdOut, cdEn, waitDone, standbyState;
	int         err_total, samples_checked, evCount, ev0;

	acd_partner_model PARTNER (.clk_sys(clk_sys), .attachCode(attachCode),
		.holdBusLow(holdBusLow), .accessoryEvent(accessoryEvent), .idCode(idCode),
		.idValid(idValid), .sclIn(sclIn), .sdaIn(sdaIn), .intReadAck(intReadAck));

	acd_autoconfig #(.BUS_HOLD_CYC(20), .WAIT_CYC(16)) DUT (.clk_sys(clk_sys), .rst(rst),
		.idCode(idCode), .idValid(idValid), .busSupplyValid(busSupplyValid),
		.usbChargerSeen(usbChargerSeen), .io_supply_level(io_supply_level), .sclIn(sclIn),
		.sdaIn(sdaIn), .intMask(intMask), .intReadAck(intReadAck), .adcCode(adcCode),
		.accessoryType(accessoryType), .keyPress(keyPress), .accessoryEvent(accessoryEvent),
		.four_position_mux(fourMux), .chargerSwitchClosed(chgSw), .jigOutLow(jigLow),
		.jigOutEn(jigEn), .bootLevel(bootLevel), .charge_detect_out(cdOut),
		.chargeDetectEn(cdEn), .switchWaitDone(waitDone), .standbyState(standbyState));

	// ----------------------------------------
	// Clock, event counter and helpers
	// ----------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) if (accessoryEvent === 1'b1) evCount <= evCount + 1;

	task chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// One cycle for the partner, one for the core, one for the event counter to count the event.
	task apply(input logic [4:0] c);
		@(posedge clk_sys);
		attachCode <= c;
		ev0 = evCount;
		repeat (3) @(posedge clk_sys);
		#1;
	endtask : apply

	task cfg(input logic [2:0] m, input logic s, j, b, c);
		chk(fourMux, m);
		chk(chgSw, s);
		chk({jigLow, jigEn, bootLevel}, {1'b0, j, b});
		chk({cdOut, cdEn}, {1'b0, c});
	endtask : cfg

	task settle(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : settle

	task defaults;
		chk(adcCode, acd_pkg::ADC_RESET);
		chk(standbyState, 1'b1);
		cfg(acd_pkg::PATH_OPEN, 1'b0, 1'b0, 1'b0, 1'b0);
	endtask : defaults

	task report_and_stop;
		if (err_total == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : report_and_stop

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_factory;
		logic [4:0] codes [4];
		codes = '{5'h18, 5'h19, 5'h1C, 5'h1D};
		foreach (codes[i]) begin
			apply(codes[i]);
			chk(accessoryType, acd_pkg::TYPE_FACTORY);
			chk(fourMux, codes[i][2] ? acd_pkg::PATH_UART : acd_pkg::PATH_USB);
			chk({chgSw, jigEn, bootLevel}, {~codes[i][2], 1'b1, codes[i][0]});
			chk(evCount - ev0, 1);
		end
	endtask : t_factory

	task t_audio_keys;
		apply(acd_pkg::ID_AUDIO_T1);
		chk(accessoryType, acd_pkg::TYPE_AUDIO);
		chk({fourMux, jigEn, bootLevel, cdEn}, {acd_pkg::PATH_AUDIO, 3'h0});
		for (int k = 1; k <= 13; k++) begin
			apply(k[4:0]);
			chk({keyPress, adcCode}, {1'b1, k[4:0]});
			chk(accessoryType, acd_pkg::TYPE_KEY);
		end
		for (int k = 14; k <= 18; k++) begin
			apply(k[4:0]);
			chk({keyPress, adcCode}, {1'b0, k[4:0]});
			chk(accessoryType, acd_pkg::TYPE_UNSUP);
			chk(fourMux, acd_pkg::PATH_OPEN);
			chk(evCount - ev0, 1);
		end
	endtask : t_audio_keys

	task t_chargers;
		busSupplyValid <= 1'b1;
		apply(acd_pkg::ID_CHG_T1);
		chk(accessoryType, acd_pkg::TYPE_CHARGER);
		chk({chgSw, cdEn}, 2'h3);
		apply(acd_pkg::ID_CHG_T2);
		chk({chgSw, cdEn}, 2'h3);
		busSupplyValid <= 1'b0;
		apply(acd_pkg::ID_CHG_T1);
		chk(accessoryType, acd_pkg::TYPE_NONE);
		chk(evCount - ev0, 0);
		chk({chgSw, cdEn}, 2'h0);
	endtask : t_chargers

	task t_uart_av;
		apply(acd_pkg::ID_UART);
		chk(accessoryType, acd_pkg::TYPE_UART);
		cfg(acd_pkg::PATH_UART, 1'b0, 1'b0, 1'b0, 1'b0);
		chk(waitDone, 1'b0);
		busSupplyValid <= 1'b1;
		settle(16);
		chk(waitDone, 1'b0);
		settle(1);
		chk(chgSw, 1'b1);
		chk(waitDone, 1'b1);
		apply(acd_pkg::ID_AV_CABLE);
		chk(accessoryType, acd_pkg::TYPE_AV);
		cfg(acd_pkg::PATH_VIDEO, 1'b1, 1'b0, 1'b0, 1'b1);
		busSupplyValid <= 1'b0;
		settle(3);
		cfg(acd_pkg::PATH_VIDEO, 1'b0, 1'b0, 1'b0, 1'b0);
	endtask : t_uart_av

	task t_open;
		busSupplyValid <= 1'b1;
		apply(acd_pkg::ID_OPEN);
		chk(accessoryType, acd_pkg::TYPE_USB);
		cfg(acd_pkg::PATH_USB, 1'b1, 1'b0, 1'b0, 1'b0);
		apply(acd_pkg::ID_UART);
		usbChargerSeen <= 1'b1;
		apply(acd_pkg::ID_OPEN);
		chk(accessoryType, acd_pkg::TYPE_DED_CHG);
		cfg(acd_pkg::PATH_OPEN, 1'b1, 1'b0, 1'b0, 1'b1);
		usbChargerSeen <= 1'b0;
	endtask : t_open

	task t_resets;
		io_supply_level <= 1'b0;
		settle(3);
		defaults();
		apply(acd_pkg::ID_UART);
		chk(evCount - ev0, 0);
		io_supply_level <= 1'b1;
		settle(3);
		chk(evCount - ev0, 1);
		intMask <= 1'b1;
		apply(acd_pkg::ID_AV_CABLE);
		chk(evCount - ev0, 0);
		intMask <= 1'b0;
		settle(3);
		chk(evCount - ev0, 1);
		// The cable stays attached, so the core finds it again after the reset.
		holdBusLow <= 1'b1;
		ev0 = evCount;
		settle(20);
		chk(standbyState, 1'b0);
		settle(1);
		defaults();
		holdBusLow <= 1'b0;
		settle(3);
		chk(evCount - ev0, 1);
		chk(adcCode, acd_pkg::ID_AV_CABLE);
		apply(acd_pkg::ID_FAC_USB_ON);
		chk(standbyState, 1'b0);
	endtask : t_resets

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		err_total = 0;
		samples_checked = 0;
		evCount = 0;
		rst = 1'b1;
		busSupplyValid = 1'b0;
		usbChargerSeen = 1'b0;
		io_supply_level = 1'b1;
		intMask = 1'b0;
		holdBusLow = 1'b0;
		attachCode = 5'h1F;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		settle(2);
		defaults();
		t_factory();
		t_audio_keys();
		t_chargers();
		t_uart_av();
		t_open();
		t_resets();
		report_and_stop();
	end

	// The whole run needs well under 2000 cycles.
	initial begin
		repeat (20000) @(posedge clk_sys);
		err_total++;
		report_and_stop();
	end
endmodule : accessory_detect_autoconfig_bench
